// >>> src/pefd_regs.svh
`ifndef PEFD_REGS_SVH
`define PEFD_REGS_SVH
// How it works
// - Bit 31 says a program-failure flag exists; absent flag frames are discarded.
// - Bit 30 set means the flag reads zero on failure.
// - Bit 29 set means one flag reports program and erase failures.
// - Bit 28 set means addressed access, clear means direct commands.
// - Bits 26 to 24 give the flag position within the read byte.
// - With addressed access, bits 23 to 16 hold the register local address.
// - With direct access, bits 23 to 20 flag 8D, 8S, 4S-4D-4D, 4S modes.
// - Single-line mode uses zero dummy cycles whatever the count field says.
// - Bits 15 to 8 are the read opcode; zero means no read command.
// - Bits 7 to 0 are the write opcode; zero means the flag is read-only.

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PE_OFF_DESC  8'h00
`define PE_OFF_CTRL  8'h04
`define PE_OFF_INFO  8'h08
`define PE_OFF_CMD   8'h0c
`define PE_OFF_ADDR  8'h10
`define PE_OFF_STAT  8'h14
`define PE_OFF_MASK  8'h18
`define PE_OFF_LAST  8'h1c

// ----------------------------------------
// Descriptor fields
// ----------------------------------------
`define PE_D_AVAIL   31
`define PE_D_POL     30
`define PE_D_SHARE   29
`define PE_D_ADDRD   28
`define PE_D_BYTE1   27
`define PE_D_POS_HI  26
`define PE_D_POS_LO  24
`define PE_D_LA_HI   23
`define PE_D_LA_LO   16
`define PE_D_M8DD    23
`define PE_D_M8SS    22
`define PE_D_M4DD    21
`define PE_D_M4SS    20
`define PE_D_DUM_HI  19
`define PE_D_DUM_LO  16
`define PE_D_RD_HI   15
`define PE_D_RD_LO   8
`define PE_D_WR_HI   7
`define PE_D_WR_LO   0

// ----------------------------------------
// Control, info and status fields
// ----------------------------------------
`define PE_C_EN      0
`define PE_C_MODE_HI 3
`define PE_C_MODE_LO 1
`define PE_C_AW_HI   5
`define PE_C_AW_LO   4
`define PE_CTRL_RST  6'h01
`define PE_MASK_RST  4'h0
`define PE_I_SHARE   2
`define PE_I_WROK    9
`define PE_S_LOAD    0
`define PE_S_FAIL    1
`define PE_S_CERR    2
`define PE_S_BADF    3

// ----------------------------------------
// Frame lengths and bus answers
// ----------------------------------------
`define PE_DESC_BITS 6'h20
`define PE_STAT_BITS 6'h08
`define PE_CNT_MAX   6'h3f
`define PE_OKAY      2'h0
`define PE_SLVERR    2'h2
`endif

// >>> src/pefd_pkg.sv
`default_nettype none
package pefd_pkg;
  typedef enum logic [2:0] {
    PEFD_M111  = 3'h0,
    PEFD_M4SSS = 3'h1,
    PEFD_M4SDD = 3'h2,
    PEFD_M8SSS = 3'h3,
    PEFD_M8DDD = 3'h4
  } pefd_mode_t;

  typedef enum logic [1:0] {
    PEFD_A8  = 2'h0,
    PEFD_A24 = 2'h1,
    PEFD_A32 = 2'h2
  } pefd_awid_t;

  typedef struct packed {
    logic        present;
    logic        inverted;
    logic        shared;
    logic        addressed;
    logic        byte1;
    logic [2:0]  bit_pos;
    logic [7:0]  loc_addr;
    logic        rd_ok;
    logic        wr_ok;
    logic        mode_ok;
    logic [3:0]  dummy;
    logic [7:0]  rd_op;
    logic [7:0]  wr_op;
    logic [31:0] addr;
    logic        cfg_err;
  } pefd_info_t;
endpackage : pefd_pkg
`default_nettype wire

// >>> src/pefd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pefd_frame_if;
  logic [31:0] word;
  logic        desc_stb;
  logic        stat_stb;
  logic        bad_stb;
  modport rx   (output word, desc_stb, stat_stb, bad_stb);
  modport core (input  word, desc_stb, stat_stb, bad_stb);
endinterface : pefd_frame_if

interface pefd_dec_if;
  import pefd_pkg::*;
  logic [31:0] desc;
  pefd_mode_t  mode;
  pefd_awid_t  awid;
  pefd_info_t  info;
  modport dec  (input  desc, mode, awid, output info);
  modport core (output desc, mode, awid, input  info);
endinterface : pefd_dec_if
`default_nettype wire

// >>> src/pefd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "pefd_regs.svh"
module pefd_decode (
  pefd_dec_if.dec d
);
  import pefd_pkg::*;

  wire direct = ~d.desc[`PE_D_ADDRD];
  wire [7:0] la = d.desc[`PE_D_LA_HI:`PE_D_LA_LO];
  wire sup_sel =
    (d.mode == PEFD_M4SSS) ? d.desc[`PE_D_M4SS] :
    (d.mode == PEFD_M4SDD) ? d.desc[`PE_D_M4DD] :
    (d.mode == PEFD_M8SSS) ? d.desc[`PE_D_M8SS] :
    (d.mode == PEFD_M8DDD) ? d.desc[`PE_D_M8DD] : 1'b0;

  assign d.info.present   = d.desc[`PE_D_AVAIL];
  assign d.info.inverted  = d.desc[`PE_D_POL];
  assign d.info.shared    = d.desc[`PE_D_SHARE];
  assign d.info.addressed = d.desc[`PE_D_ADDRD];
  assign d.info.byte1     = d.desc[`PE_D_BYTE1];
  assign d.info.bit_pos   = d.desc[`PE_D_POS_HI:`PE_D_POS_LO];
  assign d.info.loc_addr  = direct ? 8'h00 : la;
  assign d.info.rd_op     = d.desc[`PE_D_RD_HI:`PE_D_RD_LO];
  assign d.info.wr_op     = d.desc[`PE_D_WR_HI:`PE_D_WR_LO];
  assign d.info.rd_ok     = d.info.rd_op != 8'h00;
  assign d.info.wr_ok     = d.info.wr_op != 8'h00;
  // Cleared flag only reports this mode unusable at this count
  assign d.info.mode_ok   = ~direct | (d.mode == PEFD_M111) | sup_sel;
  assign d.info.dummy     = (direct & (d.mode != PEFD_M111)) ?
                            d.desc[`PE_D_DUM_HI:`PE_D_DUM_LO] : 4'h0;
  assign d.info.addr      = d.info.byte1 ? {16'h0000, d.info.loc_addr, 8'h00}
                                         : {24'h000000, d.info.loc_addr};
  assign d.info.cfg_err   = (~direct & d.info.byte1 & (d.awid == PEFD_A8)) |
                            (d.awid != PEFD_A8 && d.awid != PEFD_A24 &&
                             d.awid != PEFD_A32);
endmodule : pefd_decode
`default_nettype wire

// >>> src/pefd_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "pefd_regs.svh"
module pefd_link_rx (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic lnk_clk_i,
  input  wire logic lnk_sel_n_i,
  input  wire logic lnk_dat_i,
  pefd_frame_if.rx  f
);
  import pefd_pkg::*;

  logic [2:0]  meta_reg;
  logic [2:0]  sync_reg;
  logic [2:0]  prev_reg;
  logic [31:0] shift_reg;
  logic [5:0]  cnt_reg;
  wire  [2:0]  pins = {lnk_dat_i, lnk_sel_n_i, lnk_clk_i};
  // Idle pin levels, so reset leaves no false select edge
  localparam logic [2:0] PIN_IDLE = 3'h6;

  // ----------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_reg[i] <= PIN_IDLE[i];
          sync_reg[i] <= PIN_IDLE[i];
          prev_reg[i] <= PIN_IDLE[i];
        end else begin
          meta_reg[i] <= pins[i];
          sync_reg[i] <= meta_reg[i];
          prev_reg[i] <= sync_reg[i];
        end
      end
    end
  endgenerate

  wire clk_rise = sync_reg[0] & ~prev_reg[0];
  wire sel_fall = ~sync_reg[1] & prev_reg[1];
  wire sel_rise = sync_reg[1] & ~prev_reg[1];
  wire shift_en = ~sync_reg[1] & clk_rise & (cnt_reg != `PE_CNT_MAX);

  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_reg <= 32'h0000_0000;
      cnt_reg   <= 6'h00;
    end else if (sel_fall) begin
      cnt_reg   <= 6'h00;
    end else if (shift_en) begin
      shift_reg <= {shift_reg[30:0], sync_reg[2]};
      cnt_reg   <= cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      f.word     <= 32'h0000_0000;
      f.desc_stb <= 1'b0;
      f.stat_stb <= 1'b0;
      f.bad_stb  <= 1'b0;
    end else begin
      if (sel_rise) begin
        f.word   <= shift_reg;
      end
      f.desc_stb <= sel_rise & (cnt_reg == `PE_DESC_BITS);
      f.stat_stb <= sel_rise & (cnt_reg == `PE_STAT_BITS);
      f.bad_stb  <= sel_rise & (cnt_reg != `PE_DESC_BITS) &
                    (cnt_reg != `PE_STAT_BITS);
    end
  end
endmodule : pefd_link_rx
`default_nettype wire

// >>> src/pefd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pefd_regs.svh"
module pefd_top (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        lnk_clk_i,
  input  wire logic        lnk_sel_n_i,
  input  wire logic        lnk_dat_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             irq_o,
  output logic             fail_o
);
  import pefd_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  s);
    merge = (old_v & ~strb_mask(s)) | (new_v & strb_mask(s));
  endfunction : merge

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= `PE_OFF_LAST);
  endfunction : is_mapped

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] desc_reg;
  logic [5:0]  ctrl_reg;
  logic [3:0]  mask_reg;
  logic [3:0]  stat_reg;
  logic [7:0]  last_reg;
  logic        fail_reg;
  logic        irq_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  pefd_frame_if frm ();
  pefd_dec_if   dec ();

  pefd_link_rx u_rx (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .lnk_clk_i   (lnk_clk_i),
    .lnk_sel_n_i (lnk_sel_n_i),
    .lnk_dat_i   (lnk_dat_i),
    .f           (frm)
  );

  pefd_decode u_dec (
    .d (dec)
  );

  assign dec.desc = desc_reg;
  assign dec.mode = pefd_mode_t'(ctrl_reg[`PE_C_MODE_HI:`PE_C_MODE_LO]);
  assign dec.awid = pefd_awid_t'(ctrl_reg[`PE_C_AW_HI:`PE_C_AW_LO]);

  // ----------------------------------------
  // Flag evaluation
  // ----------------------------------------
  wire enable   = ctrl_reg[`PE_C_EN];
  wire stat_ok  = frm.stat_stb & enable & dec.info.present & dec.info.rd_ok;
  wire sel_raw  = frm.word[dec.info.bit_pos];
  wire fail_bit = sel_raw ^ dec.info.inverted;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire aw_take = s_axi_awvalid_i & awready_reg;
  wire w_take  = s_axi_wvalid_i & wready_reg;
  wire do_wr   = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire b_done  = bvalid_reg & s_axi_bready_i;
  wire ar_take = s_axi_arvalid_i & arready_reg;
  wire r_done  = rvalid_reg & s_axi_rready_i;
  wire wr_ctrl = do_wr & (awaddr_reg == `PE_OFF_CTRL);
  wire wr_stat = do_wr & (awaddr_reg == `PE_OFF_STAT);
  wire wr_mask = do_wr & (awaddr_reg == `PE_OFF_MASK);

  wire [31:0] info_word = {16'h0000, dec.info.dummy, 1'b0, dec.info.mode_ok,
                           dec.info.wr_ok, dec.info.rd_ok, dec.info.bit_pos,
                           dec.info.byte1, dec.info.addressed, dec.info.shared,
                           dec.info.inverted, dec.info.present};
  wire [31:0] cmd_word  = {8'h00, dec.info.loc_addr, dec.info.rd_op,
                           dec.info.wr_op};
  wire [31:0] ctrl_merged = merge({26'h0000000, ctrl_reg}, wdata_reg, wstrb_reg);
  wire [31:0] mask_merged = merge({28'h0000000, mask_reg}, wdata_reg, wstrb_reg);
  wire [3:0]  mask_nx     = wr_mask ? mask_merged[3:0] : mask_reg;
  wire [31:0] clr_bits    = wdata_reg & strb_mask(wstrb_reg);
  wire [3:0]  set_bits    = {frm.bad_stb, dec.info.cfg_err,
                             stat_ok & fail_bit, frm.desc_stb};
  wire [3:0]  stat_next   = (stat_reg & ~(wr_stat ? clr_bits[3:0] : 4'h0)) |
                            set_bits;

  wire [7:0]  ra = s_axi_araddr_i;
  wire [31:0] rd_mux =
    (ra == `PE_OFF_DESC) ? desc_reg :
    (ra == `PE_OFF_CTRL) ? {26'h0000000, ctrl_reg} :
    (ra == `PE_OFF_INFO) ? info_word :
    (ra == `PE_OFF_CMD)  ? cmd_word :
    (ra == `PE_OFF_ADDR) ? dec.info.addr :
    (ra == `PE_OFF_STAT) ? {28'h0000000, stat_reg} :
    (ra == `PE_OFF_MASK) ? {28'h0000000, mask_reg} :
    (ra == `PE_OFF_LAST) ? {23'h000000, fail_reg, last_reg} : 32'h0000_0000;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_reg  <= s_axi_awaddr_i;
        awready_reg <= 1'b0;
      end else if (b_done) begin
        awready_reg <= 1'b1;
      end
      if (w_take) begin
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
        wready_reg <= 1'b0;
      end else if (b_done) begin
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `PE_OKAY;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(awaddr_reg) ? `PE_OKAY : `PE_SLVERR;
    end else if (b_done) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `PE_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= is_mapped(ra) ? `PE_OKAY : `PE_SLVERR;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registers and events
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      desc_reg <= 32'h0000_0000;
      ctrl_reg <= `PE_CTRL_RST;
      mask_reg <= `PE_MASK_RST;
      stat_reg <= 4'h0;
      irq_reg  <= 1'b0;
    end else begin
      if (frm.desc_stb) begin
        desc_reg <= frm.word;
      end
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_merged[5:0];
      end
      if (wr_mask) begin
        mask_reg <= mask_merged[3:0];
      end
      // Set wins over a same-cycle clear
      stat_reg <= stat_next;
      irq_reg  <= |(stat_next & mask_nx);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_reg <= 8'h00;
      fail_reg <= 1'b0;
    end else if (stat_ok) begin
      last_reg <= frm.word[7:0];
      fail_reg <= fail_bit;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign irq_o           = irq_reg;
  assign fail_o          = fail_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  wire info_pres = dec.info.present;
  wire info_inv  = dec.info.inverted;
  wire info_adr  = dec.info.addressed;
  wire info_b1   = dec.info.byte1;
  wire [7:0] info_la  = dec.info.loc_addr;
  wire [3:0] info_dum = dec.info.dummy;

  absent_gate_a: assert property ($rose(stat_reg[`PE_S_FAIL]) |-> $past(info_pres))
    else $error("failure event from an absent flag");
  polarity_a: assert property (stat_ok |=> fail_reg == ($past(sel_raw) ^ $past(info_inv)))
    else $error("failure level ignores polarity");
  shared_read_a: assert property (ar_take && ra == `PE_OFF_INFO
      |=> s_axi_rdata_o[`PE_I_SHARE] == $past(desc_reg[`PE_D_SHARE]))
    else $error("sharing bit misreported");
  direct_addr_a: assert property (!info_adr |-> info_la == 8'h00)
    else $error("direct access shows a local address");
  byte_place_a: assert property (ar_take && ra == `PE_OFF_ADDR
      |=> s_axi_rdata_o == ($past(info_b1) ? {16'h0000, $past(info_la), 8'h00}
                                           : {24'h000000, $past(info_la)}))
    else $error("local address in wrong byte");
  byte1_narrow_a: assert property (info_adr && info_b1 && dec.awid == PEFD_A8
      |=> stat_reg[`PE_S_CERR])
    else $error("byte 1 with 8-bit addressing not flagged");
  local_addr_a: assert property (info_adr |-> info_la == desc_reg[`PE_D_LA_HI:`PE_D_LA_LO])
    else $error("local address mismatch");
  dummy_count_a: assert property (!info_adr && dec.mode != PEFD_M111
      |-> info_dum == desc_reg[`PE_D_DUM_HI:`PE_D_DUM_LO])
    else $error("dummy count mismatch");
  single_zero_a: assert property (dec.mode == PEFD_M111 |-> info_dum == 4'h0)
    else $error("single-line mode uses dummy cycles");
  no_read_a: assert property (frm.stat_stb && !dec.info.rd_ok
      |=> $stable(fail_reg) && $stable(last_reg))
    else $error("status taken without read command");
  read_only_a: assert property (ar_take && ra == `PE_OFF_INFO
      |=> s_axi_rdata_o[`PE_I_WROK] == ($past(desc_reg[`PE_D_WR_HI:`PE_D_WR_LO]) != 8'h00))
    else $error("write support misdecoded");
  irq_level_a: assert property (irq_o == |(stat_reg & mask_reg))
    else $error("interrupt level differs from unmasked status");
  write_resp_a: assert property (aw_take && w_take |=> ##1 s_axi_bvalid_o)
    else $error("write response late");

  load_c: cover property (frm.desc_stb ##1 info_pres);
  fail_c: cover property (stat_ok && fail_bit);
  cerr_c: cover property ($rose(stat_reg[`PE_S_CERR]));
  irq_c:  cover property ($rose(irq_o));
endmodule : pefd_top
`default_nettype wire

// >>> tb/pefd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pefd_mem_model (
  output logic lnk_clk_o,
  output logic lnk_sel_n_o,
  output logic lnk_dat_o
);
  initial begin
    lnk_clk_o   = 1'b0;
    lnk_sel_n_o = 1'b1;
    lnk_dat_o   = 1'b1;
  end
  // Clock idle between frames, data flips on release
  task automatic send(input logic [31:0] w, input int n);
    #37;
    lnk_sel_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      lnk_dat_o = w[i];
      #400 lnk_clk_o = 1'b1;
      #400 lnk_clk_o = 1'b0;
    end
    #400 lnk_sel_n_o = 1'b1;
    lnk_dat_o = ~lnk_dat_o;
  endtask : send
  // Status byte, other bits opposite to the flag
  task automatic status(input logic [2:0] pos, input logic failed, input logic inv);
    logic [7:0] b;
    b      = {8{~(failed ^ inv)}};
    b[pos] = failed ^ inv;
    send({24'h0, b}, 8);
  endtask : status
endmodule : pefd_mem_model
`default_nettype wire

// >>> tb/program_error_descriptor_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pefd_regs.svh"
module program_error_descriptor_decoder_tb_top;
  localparam logic [5:0] OKV = 6'b010101;
  logic        clk, rst_n, lclk, lsel_n, ldat, irq, fail;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  int          fail_count, cmp_count;

  pefd_top uut (.sys_clk_i(clk), .reset_n_i(rst_n), .lnk_clk_i(lclk), .lnk_sel_n_i(lsel_n),
    .lnk_dat_i(ldat), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .irq_o(irq), .fail_o(fail));
  pefd_mem_model mem (.lnk_clk_o(lclk), .lnk_sel_n_o(lsel_n), .lnk_dat_o(ldat));

  always #50 clk = ~clk;

  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [1:0] er(input logic [7:0] a);
    return (a > `PE_OFF_LAST || a[1:0] != 2'h0) ? `PE_SLVERR : `PE_OKAY;
  endfunction : er
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    chk("bresp", {29'h0, 1'b1, er(a)}, {29'h0, bvalid, bresp});
    bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    chk($sformatf("reg %h", a), e, rdata & m);
    chk("rresp", {29'h0, 1'b1, er(a)}, {29'h0, rvalid, rresp});
    rready <= 1'b0;
  endtask : rc
  task automatic lk(input logic [31:0] w, input int n);
    mem.send(w, n);
    repeat (8) @(posedge clk);
  endtask : lk
  task automatic st(input logic [2:0] p, input logic f, input logic v, input logic e);
    mem.status(p, f, v);
    repeat (8) @(posedge clk);
    chk("fail_o", {31'h0, e}, {31'h0, fail});
  endtask : st
  task automatic iq(input logic e);
    repeat (2) @(posedge clk);
    chk("irq_o", {31'h0, e}, {31'h0, irq});
  endtask : iq
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ----
  // Tests
  // ----
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(`PE_OFF_CTRL, 32'h3f, 32'h1);
    rc(`PE_OFF_DESC, '1, 32'h0);
    rc(8'h20, '1, 32'h0);
    rc(8'h06, '1, 32'h0);
    wr(8'h24, 32'h1);
    wr(`PE_OFF_MASK, 32'hf);
    rc(`PE_OFF_MASK, '1, 32'hf);
    st(3'h0, 1'b1, 1'b0, 1'b0);
    rc(`PE_OFF_LAST, 32'h1ff, 32'h0);
    lk(32'ha5a90500, 32);
    rc(`PE_OFF_DESC, '1, 32'ha5a90500);
    rc(`PE_OFF_STAT, 32'hf, 32'h1);
    iq(1'b1);
    wstrb <= 4'h0;
    wr(`PE_OFF_STAT, 32'h1);
    rc(`PE_OFF_STAT, 32'hf, 32'h1);
    wstrb <= 4'hf;
    wr(`PE_OFF_STAT, 32'h1);
    iq(1'b0);
    rc(`PE_OFF_INFO, 32'hf7ff, 32'h5a5);
    rc(`PE_OFF_CMD, 32'hffffff, 32'h500);
    for (int m = 0; m < 6; m++) begin
      wr(`PE_OFF_CTRL, 32'h1 | (m << 1));
      rc(`PE_OFF_INFO, OKV[m] ? 32'hf400 : 32'h400,
         OKV[m] ? {(m == 0) ? 4'h0 : 4'h9, 12'h400} : 32'h0);
    end
    wr(`PE_OFF_CTRL, 32'h1);
    st(3'h5, 1'b1, 1'b0, 1'b1);
    rc(`PE_OFF_LAST, 32'h1ff, 32'h120);
    rc(`PE_OFF_STAT, 32'hf, 32'h2);
    iq(1'b1);
    wr(`PE_OFF_MASK, 32'h0);
    iq(1'b0);
    wr(`PE_OFF_MASK, 32'hf);
    wr(`PE_OFF_STAT, 32'h2);
    iq(1'b0);
    st(3'h5, 1'b0, 1'b0, 1'b0);
    rc(`PE_OFF_STAT, 32'hf, 32'h0);
    lk(32'hda3c7071, 32);
    rc(`PE_OFF_STAT, 32'h4, 32'h4);
    wr(`PE_OFF_CTRL, 32'h11);
    wr(`PE_OFF_STAT, 32'hf);
    rc(`PE_OFF_STAT, 32'hf, 32'h0);
    rc(`PE_OFF_ADDR, '1, 32'h3c00);
    rc(`PE_OFF_CMD, 32'hffffff, 32'h3c7071);
    rc(`PE_OFF_INFO, 32'hf7ff, 32'h75b);
    st(3'h2, 1'b1, 1'b1, 1'b1);
    st(3'h2, 1'b0, 1'b1, 1'b0);
    wr(`PE_OFF_CTRL, 32'h31);
    rc(`PE_OFF_STAT, 32'h4, 32'h4);
    wr(`PE_OFF_CTRL, 32'h21);
    lk(32'hd23c7071, 32);
    rc(`PE_OFF_ADDR, '1, 32'h3c);
    rc(`PE_OFF_INFO, 32'h10, 32'h0);
    lk(32'h80000000, 32);
    st(3'h0, 1'b1, 1'b0, 1'b0);
    wr(`PE_OFF_STAT, 32'hf);
    lk(32'h5, 5);
    rc(`PE_OFF_STAT, 32'hf, 32'h8);
    results();
  end

  initial begin
    #2000000;
    fail_count++;
    results();
  end
endmodule : program_error_descriptor_decoder_tb_top
`default_nettype wire
